// >>> src/cal_store_cfg.svh
// Named constants for the calibration store controller.
`ifndef CAL_STORE_CFG_SVH
`define CAL_STORE_CFG_SVH
`define CLK_SYS_HZ 25000000
`define PAGE_LAST 2'h3
`define PAGE_WORDS 24
`define STORE_DEPTH 96
`define IDX_W 7
`define ADDR_LAST 5'h17
`define CFG_ADDR 5'h10
`define OFS_MSB 2
`define OFS_LSB 0
`define GAIN_MSB 6
`define GAIN_LSB 3
`define BSEG_MSB 8
`define BSEG_LSB 7
`define TSEG_MSB 10
`define TSEG_LSB 9
`define GRP_READ 3'h0
`define GRP_STAT 3'h1
`define GRP_WRITE 3'h2
`define CMD_PAGE_ADV 8'h5E
`define CMD_MEASURE 8'hAC
`define STAT_BUSY 5
`define STAT_FULL 2
`define STAT_ERR 0
`define MSTAT_PROG 0
`define MSTAT_LOCKED 1
`define FACT_TEMP_OFS 3'h3
`define FACT_TEMP_GAIN 4'h5
`define WORD_ALL_SET 16'hFFFF
`define SYNC_FILL 2'h2
`endif

// >>> src/cal_store_pkg.sv
// Types shared by the calibration store controller.
`default_nettype none
package cal_store_pkg;
    typedef enum logic [1:0] {st_sleep, st_bridge, st_temp, st_correct} meas_state_e;
    typedef logic [15:0] word_t;
endpackage : cal_store_pkg
`default_nettype wire

// >>> src/store_if.sv
// Connection between the controller and the page array.
`timescale 1ns/1ps
`default_nettype none
interface store_if;
    logic wr_en;
    logic [1:0] page;
    logic [4:0] addr;
    cal_store_pkg::word_t wdata;
    cal_store_pkg::word_t rd_data;
    cal_store_pkg::word_t cfg_word;
    modport ctrl (output wr_en, page, addr, wdata, input rd_data, cfg_word);
    modport store (input wr_en, page, addr, wdata, output rd_data, cfg_word);
endinterface : store_if
`default_nettype wire

// >>> src/otp_page_array.sv
// One-time programmable page array with OR-only writes.
`timescale 1ns/1ps
`default_nettype none
`include "cal_store_cfg.svh"
module otp_page_array (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Controller side.
    store_if.store mem
);
    cal_store_pkg::word_t mem_q [`STORE_DEPTH];
    cal_store_pkg::word_t mem_d [`STORE_DEPTH];
    logic [`IDX_W-1:0] acc_idx;
    logic [`IDX_W-1:0] cfg_idx;

    always_comb begin
        acc_idx = `IDX_W'(`IDX_W'(mem.page) * `IDX_W'(`PAGE_WORDS) + `IDX_W'(mem.addr));
        cfg_idx = `IDX_W'(`IDX_W'(mem.page) * `IDX_W'(`PAGE_WORDS) + `IDX_W'(`CFG_ADDR));
        mem.rd_data = (acc_idx < `IDX_W'(`STORE_DEPTH)) ? mem_q[acc_idx] : '0;
        mem.cfg_word = mem_q[cfg_idx];
    end

    for (genvar g = 0; g < `STORE_DEPTH; g++) begin : g_word
        always_comb begin
            mem_d[g] = mem_q[g];
            if (mem.wr_en && acc_idx == `IDX_W'(g)) begin
                mem_d[g] = mem_q[g] | mem.wdata; // [RL10] [RL11]
            end
        end
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                mem_q[g] <= '0;
            end else begin
                mem_q[g] <= mem_d[g];
            end
        end
    end

    a_or_merge: assert property ( // [RL11]
        @(posedge clk_sys) disable iff (!nrst)
        mem.wr_en |=> mem_q[$past(acc_idx)] == ($past(mem.rd_data) | $past(mem.wdata)))
        else $error("Write did not leave the OR of old and new.");

    a_bits_never_clear: assert property ( // [RL10]
        @(posedge clk_sys) disable iff (!nrst)
        ($stable(mem.page) && $past(nrst)) |-> ((mem.cfg_word & $past(mem.cfg_word)) == $past(mem.cfg_word)))
        else $error("A programmed bit went back to zero.");
endmodule : otp_page_array
`default_nettype wire

// >>> src/iface_strap.sv
// Interface select strap capture.
`timescale 1ns/1ps
`default_nettype none
`include "cal_store_cfg.svh"
module iface_strap (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Strap pin.
    input wire logic sel_pin,
    // Result.
    output logic io_mode_i2c,
    output logic sel_pullup_en
);
    logic sync1_q;
    logic sync2_q;
    logic [1:0] fill_q;
    logic [1:0] fill_d;
    logic taken_q;
    logic taken_d;
    logic mode_q;
    logic mode_d;
    logic pull_q;

    always_comb begin
        fill_d = fill_q;
        taken_d = taken_q;
        mode_d = mode_q;
        if (!taken_q) begin
            if (fill_q == `SYNC_FILL) begin
                mode_d = sync2_q; // [RL15]
                taken_d = 1'b1;
            end else begin
                fill_d = fill_q + 2'h1;
            end
        end
    end

    // The pull-up stays on, so an open pin reads high.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 1'b1; // [RL16]
            sync2_q <= 1'b1;
            fill_q <= 2'h0;
            taken_q <= 1'b0;
            mode_q <= 1'b1; // [RL16]
            pull_q <= 1'b1;
        end else begin
            sync1_q <= sel_pin;
            sync2_q <= sync1_q;
            fill_q <= fill_d;
            taken_q <= taken_d;
            mode_q <= mode_d;
            pull_q <= 1'b1;
        end
    end

    assign io_mode_i2c = mode_q;
    assign sel_pullup_en = pull_q;

    a_mode_capture: assert property ( // [RL15]
        @(posedge clk_sys) disable iff (!nrst)
        $rose(taken_q) |-> mode_q == $past(sync2_q))
        else $error("Interface mode not taken from the strap.");

    a_mode_frozen: assert property ( // [RL15]
        @(posedge clk_sys) disable iff (!nrst)
        (taken_q && $past(taken_q)) |-> $stable(mode_q))
        else $error("Interface mode changed after capture.");
endmodule : iface_strap
`default_nettype wire

// >>> src/otp_calibration_store_ctrl.sv
// Calibration store controller with conversion sequencing and strap decode.
// What the document asks of the block and its host
// RL1 - ADC offset selectable in eight steps
// RL2 - Offset code from config word 10h
// RL3 - Code n gives offset (n+1)/16
// RL4 - Temperature uses factory offset and gain
// RL5 - Done only after measurement and correction
// RL6 - Four pages, one currently valid
// RL7 - Host advances page before rewriting contents
// RL8 - Each page holds 24 sixteen-bit words
// RL9 - Factory values unreachable by user commands
// RL10 - No erase, bits never clear; the code zeroes the whole page array on every nrst reset
// RL11 - Write stores OR of old, new
// RL12 - Host rewrites only when OR equals new
// RL13 - Logic runs from one trimmed clock
// RL14 - Supervisor reset clears all digital state
// RL15 - Select pin low SPI, high I2C
// RL16 - Open select pin defaults to I2C
// RL17 - Host may leave SPI pins open
// RL18 - Interface answers while rest sleeps
// RL19 - Read, status +20h, write +40h
// RL20 - Writes refused and full flagged
// RL21 - Done drops at new measurement start
`timescale 1ns/1ps
`default_nettype none
`include "cal_store_cfg.svh"
module otp_calibration_store_ctrl (
    // Clock and supervisor reset.
    input wire logic clk_sys,
    input wire logic nrst,
    // Command port.
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [15:0] cmd_data,
    // Response port.
    output logic rsp_valid,
    output logic [7:0] rsp_status,
    output logic [15:0] rsp_data,
    // Conversion control.
    input wire logic adc_done,
    input wire logic dsp_done,
    output logic adc_start,
    output logic meas_temp,
    output logic lv_active,
    output logic eoc,
    output logic [2:0] adc_offset_select,
    output logic [3:0] amp_gain_select,
    output logic [1:0] adc_segment_select,
    // Interface strap.
    input wire logic sel_pin,
    output logic io_mode_i2c,
    output logic sel_pullup_en,
    // Page state.
    output logic [1:0] page_index,
    output logic mem_full
);
    // ****************************************
    // Declarations.
    // ****************************************
    store_if port();
    logic [2:0] grp;
    logic addr_ok;
    logic start_meas;
    logic cmd_err;
    logic [1:0] page_q;
    logic [1:0] page_d;
    logic full_q;
    logic full_d;
    logic rsp_valid_q;
    logic rsp_valid_d;
    logic [7:0] rsp_status_q;
    logic [7:0] rsp_status_d;
    logic [15:0] rsp_data_q;
    logic [15:0] rsp_data_d;
    cal_store_pkg::meas_state_e state_q;
    cal_store_pkg::meas_state_e state_d;
    logic eoc_q;
    logic eoc_d;
    logic adc_start_q;
    logic adc_start_d;
    logic temp_q;
    logic temp_d;
    logic lv_q;
    logic lv_d;
    logic [2:0] ofs_q;
    logic [2:0] ofs_d;
    logic [3:0] gain_q;
    logic [3:0] gain_d;
    logic [1:0] seg_q;
    logic [1:0] seg_d;

    // ****************************************
    // Sub-blocks.
    // ****************************************
    otp_page_array u_array (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .mem(port.store)
    );

    iface_strap u_strap (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .sel_pin(sel_pin),
        .io_mode_i2c(io_mode_i2c),
        .sel_pullup_en(sel_pullup_en)
    );

    // ****************************************
    // Command decode, answered in every state; measure starts only from sleep.
    // ****************************************
    always_comb begin
        grp = cmd_byte[7:5];
        addr_ok = cmd_byte[4:0] <= `ADDR_LAST; // [RL8]
        start_meas = cmd_valid && cmd_byte == `CMD_MEASURE && state_q == cal_store_pkg::st_sleep;
        port.page = page_q; // [RL6]
        port.addr = cmd_byte[4:0];
        port.wdata = cmd_data;
        port.wr_en = 1'b0;
        page_d = page_q;
        full_d = full_q;
        cmd_err = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_status_d = rsp_status_q;
        rsp_data_d = rsp_data_q;
        if (cmd_valid) begin // [RL18]
            rsp_valid_d = 1'b1;
            rsp_data_d = '0;
            if (grp == `GRP_READ && addr_ok) begin
                rsp_data_d = port.rd_data; // [RL19]
            end else if (grp == `GRP_STAT && addr_ok) begin
                rsp_data_d[`MSTAT_PROG] = |port.rd_data; // [RL19]
                rsp_data_d[`MSTAT_LOCKED] = port.rd_data == `WORD_ALL_SET;
            end else if (grp == `GRP_WRITE && addr_ok) begin
                port.wr_en = !full_q; // [RL19] [RL20]
                cmd_err = full_q;
            end else if (cmd_byte == `CMD_PAGE_ADV) begin
                if (page_q == `PAGE_LAST) begin
                    full_d = 1'b1; // [RL20]
                end else begin
                    page_d = page_q + 2'h1; // [RL6]
                end
            end else if (!start_meas) begin
                cmd_err = 1'b1;
            end
            rsp_status_d = '0;
            rsp_status_d[`STAT_BUSY] = state_q != cal_store_pkg::st_sleep;
            rsp_status_d[`STAT_FULL] = full_d; // [RL20]
            rsp_status_d[`STAT_ERR] = cmd_err;
        end
    end

    // The whole block runs on the single system clock.
    always_ff @(posedge clk_sys or negedge nrst) begin // [RL13]
        if (!nrst) begin // [RL14]
            page_q <= 2'h0;
            full_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_status_q <= 8'h00;
            rsp_data_q <= 16'h0000;
        end else begin
            page_q <= page_d;
            full_q <= full_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_status_q <= rsp_status_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    // ****************************************
    // Measurement sequence.
    // ****************************************
    always_comb begin
        state_d = state_q;
        eoc_d = eoc_q;
        adc_start_d = 1'b0;
        unique case (state_q)
            cal_store_pkg::st_sleep: begin
                if (start_meas) begin
                    state_d = cal_store_pkg::st_bridge;
                    eoc_d = 1'b0; // [RL21]
                    adc_start_d = 1'b1;
                end
            end
            cal_store_pkg::st_bridge: begin
                if (adc_done) begin
                    state_d = cal_store_pkg::st_temp;
                    adc_start_d = 1'b1;
                end
            end
            cal_store_pkg::st_temp: begin
                if (adc_done) begin
                    state_d = cal_store_pkg::st_correct;
                end
            end
            cal_store_pkg::st_correct: begin
                if (dsp_done) begin
                    state_d = cal_store_pkg::st_sleep;
                    eoc_d = 1'b1; // [RL5]
                end
            end
        endcase
        temp_d = state_d == cal_store_pkg::st_temp;
        lv_d = state_d != cal_store_pkg::st_sleep;
        // Factory settings stay in constants with no command path to them.
        ofs_d = temp_d ? `FACT_TEMP_OFS : port.cfg_word[`OFS_MSB:`OFS_LSB]; // [RL1] [RL2] [RL3] [RL4] [RL9]
        gain_d = temp_d ? `FACT_TEMP_GAIN : port.cfg_word[`GAIN_MSB:`GAIN_LSB]; // [RL4]
        seg_d = temp_d ? port.cfg_word[`TSEG_MSB:`TSEG_LSB] : port.cfg_word[`BSEG_MSB:`BSEG_LSB];
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin // [RL14]
            state_q <= cal_store_pkg::st_sleep;
            eoc_q <= 1'b0;
            adc_start_q <= 1'b0;
            temp_q <= 1'b0;
            lv_q <= 1'b0;
            ofs_q <= 3'h0;
            gain_q <= 4'h0;
            seg_q <= 2'h0;
        end else begin
            state_q <= state_d;
            eoc_q <= eoc_d;
            adc_start_q <= adc_start_d;
            temp_q <= temp_d;
            lv_q <= lv_d;
            ofs_q <= ofs_d;
            gain_q <= gain_d;
            seg_q <= seg_d;
        end
    end

    // ****************************************
    // Outputs.
    // ****************************************
    assign rsp_valid = rsp_valid_q;
    assign rsp_status = rsp_status_q;
    assign rsp_data = rsp_data_q;
    assign adc_start = adc_start_q;
    assign meas_temp = temp_q;
    assign lv_active = lv_q;
    assign eoc = eoc_q;
    assign adc_offset_select = ofs_q;
    assign amp_gain_select = gain_q;
    assign adc_segment_select = seg_q;
    assign page_index = page_q;
    assign mem_full = full_q;

    // ****************************************
    // Checks.
    // ****************************************
    a_eoc_after_calc: assert property ( // [RL5]
        @(posedge clk_sys) disable iff (!nrst)
        $rose(eoc_q) |-> $past(state_q == cal_store_pkg::st_correct && dsp_done))
        else $error("Done rose without finished correction.");

    a_eoc_low_busy: assert property ( // [RL21]
        @(posedge clk_sys) disable iff (!nrst)
        start_meas |=> !eoc_q throughout (state_q != cal_store_pkg::st_sleep)[*1])
        else $error("Done not cleared at measurement start.");

    a_eoc_held_low: assert property ( // [RL21]
        @(posedge clk_sys) disable iff (!nrst)
        (state_q != cal_store_pkg::st_sleep) |-> !eoc_q)
        else $error("Done high during a measurement.");

    a_offset_from_cfg: assert property ( // [RL2]
        @(posedge clk_sys) disable iff (!nrst)
        (state_q == cal_store_pkg::st_bridge && $past(state_q == cal_store_pkg::st_bridge))
        |-> adc_offset_select == $past(port.cfg_word[`OFS_MSB:`OFS_LSB]))
        else $error("Bridge offset not taken from the config word.");

    a_temp_factory: assert property ( // [RL4]
        @(posedge clk_sys) disable iff (!nrst)
        meas_temp |-> (adc_offset_select == `FACT_TEMP_OFS && amp_gain_select == `FACT_TEMP_GAIN))
        else $error("Temperature conversion not on factory settings.");

    a_full_refuses: assert property ( // [RL20]
        @(posedge clk_sys) disable iff (!nrst)
        (cmd_valid && grp == `GRP_WRITE && addr_ok && full_q)
        |-> !port.wr_en ##1 (rsp_status[`STAT_FULL] && rsp_status[`STAT_ERR]))
        else $error("Write accepted after the store was full.");

    a_page_advance: assert property ( // [RL6]
        @(posedge clk_sys) disable iff (!nrst)
        (cmd_valid && cmd_byte == `CMD_PAGE_ADV && page_q != `PAGE_LAST)
        |=> page_q == $past(page_q) + 2'h1)
        else $error("Page counter did not advance by one.");

    a_answer_next: assert property ( // [RL19]
        @(posedge clk_sys) disable iff (!nrst)
        cmd_valid |=> rsp_valid ##1 (rsp_valid == $past(cmd_valid)))
        else $error("Command not answered on the next cycle.");

    c_meas_done: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(eoc_q));
    c_store_full: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(full_q));
    c_word_write: cover property (@(posedge clk_sys) disable iff (!nrst) port.wr_en);
endmodule : otp_calibration_store_ctrl
`default_nettype wire

// >>> sim/conv_engine_model.sv
// Behavioural model of the ADC and correction engine behind the block.
`timescale 1ns/1ps
`default_nettype none
module conv_engine_model #(
    parameter int LAT = 4
) (
    // Clock.
    input wire logic clk_sys,
    // Requests from the block.
    input wire logic adc_start,
    // Completion pulses.
    output logic adc_done,
    output logic dsp_done
);
    int adc_cnt = 0;
    int dsp_cnt = 0;
    int n_conv = 0;
    initial begin
        adc_done = 1'b0;
        dsp_done = 1'b0;
    end
    // Each conversion ends LAT cycles after its start; correction follows the second one.
    always @(negedge clk_sys) begin
        adc_done <= 1'b0;
        dsp_done <= 1'b0;
        if (adc_start === 1'b1) begin
            adc_cnt <= LAT;
            n_conv <= n_conv + 1;
        end else if (adc_cnt > 0) begin
            adc_cnt <= adc_cnt - 1;
            if (adc_cnt == 1) begin
                adc_done <= 1'b1;
                if (n_conv == 2) begin
                    dsp_cnt <= LAT;
                end
            end
        end
        if (dsp_cnt > 0) begin
            dsp_cnt <= dsp_cnt - 1;
            if (dsp_cnt == 1) begin
                dsp_done <= 1'b1;
                n_conv <= 0;
            end
        end
    end
endmodule : conv_engine_model
`default_nettype wire

// >>> sim/test_otp_calibration_store_ctrl.sv
// Self-checking testbench for the calibration store controller.
`timescale 1ns/1ps
`default_nettype none
`include "cal_store_cfg.svh"
module test_otp_calibration_store_ctrl;
    logic clk_sys, nrst, cmd_valid, adc_done, dsp_done, sel_drv_en, sel_drv;
    logic [7:0] cmd_byte, rsp_status, st_got;
    logic [15:0] cmd_data, rsp_data, dt_got;
    logic rsp_valid, adc_start, meas_temp, lv_active, eoc, io_mode_i2c, sel_pullup_en, mem_full;
    logic [2:0] adc_offset_select;
    logic [3:0] amp_gain_select;
    logic [1:0] adc_segment_select, page_index;
    wire sel_pin;
    int n_mismatch, checked;

    // ****************************************
    // Design, engine model and strap pin.
    // ****************************************
    assign sel_pin = sel_drv_en ? sel_drv : (sel_pullup_en === 1'b1 ? 1'b1 : 1'bx);
    otp_calibration_store_ctrl uut (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
        .rsp_data(rsp_data), .adc_done(adc_done), .dsp_done(dsp_done), .adc_start(adc_start),
        .meas_temp(meas_temp), .lv_active(lv_active), .eoc(eoc), .adc_offset_select(adc_offset_select),
        .amp_gain_select(amp_gain_select), .adc_segment_select(adc_segment_select), .sel_pin(sel_pin),
        .io_mode_i2c(io_mode_i2c), .sel_pullup_en(sel_pullup_en), .page_index(page_index),
        .mem_full(mem_full));
    conv_engine_model #(.LAT(4)) engine (.clk_sys(clk_sys), .adc_start(adc_start), .adc_done(adc_done),
        .dsp_done(dsp_done));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_byte = code;
        cmd_data = data;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        chk({15'h0, rsp_valid}, 16'h0001);
        st_got = rsp_status;
        dt_got = rsp_data;
    endtask : cmd

    task automatic do_reset(input logic en, input logic val);
        @(negedge clk_sys);
        nrst = 1'b0;
        cmd_valid = 1'b0;
        sel_drv_en = en;
        sel_drv = val;
        repeat (5) @(negedge clk_sys);
        chk({eoc, lv_active, mem_full, page_index, adc_offset_select, io_mode_i2c, sel_pullup_en},
            16'h0003);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask : do_reset

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_strap;
        do_reset(1'b1, 1'b0);
        chk({15'h0, io_mode_i2c}, 16'h0000);
        do_reset(1'b1, 1'b1);
        chk({15'h0, io_mode_i2c}, 16'h0001);
        do_reset(1'b0, 1'b0);
        chk({14'h0, io_mode_i2c, sel_pullup_en}, 16'h0003);
    endtask : t_strap

    task automatic t_store;
        logic [7:0] bad [4];
        bad = '{8'h18, 8'h3F, 8'h58, 8'h5F};
        cmd(8'h51, 16'h8421);
        chk({8'h0, st_got}, 16'h0000);
        cmd(8'h51, 16'h2286);
        cmd(8'h11, 16'h0000);
        chk(dt_got, 16'hA6A7);
        chk({15'h0, lv_active}, 16'h0000);
        cmd(8'h31, 16'h0000);
        chk(dt_got, 16'h0001);
        cmd(8'h40, 16'hFFFF);
        cmd(8'h40, 16'h0000);
        cmd(8'h00, 16'h0000);
        chk(dt_got, 16'hFFFF);
        cmd(8'h20, 16'h0000);
        chk(dt_got, 16'h0003);
        cmd(8'h57, 16'h00F0);
        cmd(8'h17, 16'h0000);
        chk(dt_got, 16'h00F0);
        foreach (bad[i]) begin
            cmd(bad[i], 16'h0001);
            chk({15'h0, st_got[`STAT_ERR]}, 16'h0001);
            chk(dt_got, 16'h0000);
        end
    endtask : t_store

    task automatic t_pages;
        for (int p = 1; p < 4; p++) begin
            cmd(`CMD_PAGE_ADV, 16'h0000);
            chk({14'h0, page_index}, p[15:0]);
            cmd(8'h11, 16'h0000);
            chk(dt_got, 16'h0000);
        end
        cmd(8'h45, 16'h0F0F);
        cmd(`CMD_PAGE_ADV, 16'h0000);
        chk({mem_full, page_index, st_got}, 16'h0704);
        cmd(8'h45, 16'h1234);
        chk({8'h0, st_got}, 16'h0005);
        cmd(8'h05, 16'h0000);
        chk(dt_got, 16'h0F0F);
    endtask : t_pages

    task automatic t_measure(input logic [2:0] n);
        int i;
        logic [15:0] cfg;
        cfg = {5'h0, 2'h1, 2'h2, 4'h9, n};
        do_reset(1'b1, 1'b1);
        cmd(8'h50, cfg);
        cmd(`CMD_MEASURE, 16'h0000);
        chk({adc_start, lv_active, eoc, adc_offset_select, amp_gain_select, adc_segment_select},
            {4'h0, 3'b110, n, 4'h9, 2'h2});
        for (i = 0; i < 50 && meas_temp !== 1'b1; i++) @(negedge clk_sys);
        chk({meas_temp, adc_offset_select, amp_gain_select, adc_segment_select},
            {6'h1, `FACT_TEMP_OFS, `FACT_TEMP_GAIN, 2'h1});
        cmd(`CMD_MEASURE, 16'h0000);
        chk({8'h0, st_got}, 16'h0021);
        chk({15'h0, eoc}, 16'h0000);
        for (i = 0; i < 50 && meas_temp !== 1'b0; i++) @(negedge clk_sys);
        chk({14'h0, eoc, lv_active}, 16'h0001);
        for (i = 0; i < 50 && eoc !== 1'b1; i++) @(negedge clk_sys);
        chk({14'h0, eoc, lv_active}, 16'h0002);
        cmd(`CMD_MEASURE, 16'h0000);
        chk({15'h0, eoc}, 16'h0000);
        for (i = 0; i < 80 && eoc !== 1'b1; i++) @(negedge clk_sys);
        chk({15'h0, eoc}, 16'h0001);
    endtask : t_measure

    // ****************************************
    // Main sequence and watchdog.
    // ****************************************
    initial begin
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        cmd_data = 16'h0000;
        sel_drv_en = 1'b1;
        sel_drv = 1'b1;
        n_mismatch = 0;
        checked = 0;
        t_strap();
        t_store();
        t_pages();
        for (int n = 0; n < 8; n++) begin
            t_measure(n[2:0]);
        end
        conclude();
    end

    initial begin
        #(5000 * 40);
        n_mismatch++;
        conclude();
    end
endmodule : test_otp_calibration_store_ctrl
`default_nettype wire
